// File: rtl/sft_baud_gen.v
// Baud tick divider: one-cycle tick every divisor+1 clocks
`timescale 1ns/100ps
`default_nettype none
module sft_baud_gen #(
    parameter W = 12
) (
    // Clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // Control
    input  wire         reload,
    input  wire [W-1:0] divisor,
    // Output
    output reg          tick
);
    reg [W-1:0] cnt_q;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= {W{1'b0}};
            tick  <= 1'b0;
        end
        else if (reload)
        begin
            cnt_q <= divisor;
            tick  <= 1'b0;
        end
        else if (cnt_q == {W{1'b0}})
        begin
            cnt_q <= divisor;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: rtl/sft_map.vh
// Register map, field positions and constants of the serial frame transmitter
`ifndef SFT_MAP_VH
`define SFT_MAP_VH

// Byte offsets
`define SFT_OFF_DATA      8'h00
`define SFT_OFF_STATUS    8'h04
`define SFT_OFF_CTRL      8'h08
`define SFT_OFF_FORMAT    8'h0c
`define SFT_OFF_BAUD      8'h10
`define SFT_ADDR_W        8

// Status fields
`define SFT_ST_BUF_FREE   0
`define SFT_ST_DONE       1
`define SFT_ST_BUSY       2
`define SFT_ST_DONE_W1C   32'h0000_0002

// Control fields
`define SFT_CT_TX_ON      0
`define SFT_CT_NINTH      1
`define SFT_CT_DOUBLE     2
`define SFT_CT_SYNC       3

// Format fields
`define SFT_FM_SIZE_LO    0
`define SFT_FM_SIZE_HI    2
`define SFT_FM_PAR_LO     3
`define SFT_FM_PAR_HI     4
`define SFT_FM_STOP       5
`define SFT_FMT_RESET     6'h03

// Baud divisor field
`define SFT_BAUD_W        12

// Character size codes
`define SFT_SIZE_5        3'h0
`define SFT_SIZE_6        3'h1
`define SFT_SIZE_7        3'h2
`define SFT_SIZE_8        3'h3
`define SFT_SIZE_9        3'h7

// Oversampling per bit
`define SFT_OVS_NORMAL    5'h10
`define SFT_OVS_DOUBLE    5'h08

// AXI responses
`define SFT_RESP_OKAY     2'h0
`define SFT_RESP_SLVERR   2'h2

`endif

// File: rtl/sft_transmitter.v
// Serial frame transmitter with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "sft_map.vh"
module sft_transmitter #(
    parameter BAUD_W = 12
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Serial pins
    input  wire        sync_clock_pin,
    input  wire        port_out,
    output reg         serial_out_pin,
    output reg         tx_pin_owned
);
    localparam ST_IDLE   = 3'h0;
    localparam ST_START  = 3'h1;
    localparam ST_DATA   = 3'h2;
    localparam ST_PARITY = 3'h3;
    localparam ST_STOP1  = 3'h4;
    localparam ST_STOP2  = 3'h5;

    // Number of data bits for a size code
    function [3:0] data_bits;
        input [2:0] code;
        begin
            case (code)
                `SFT_SIZE_5: data_bits = 4'h5;
                `SFT_SIZE_6: data_bits = 4'h6;
                `SFT_SIZE_7: data_bits = 4'h7;
                `SFT_SIZE_9: data_bits = 4'h9;
                default:     data_bits = 4'h8;
            endcase
        end
    endfunction

    // Mask of valid data bits for a size code
    function [8:0] data_mask;
        input [2:0] code;
        begin
            data_mask = ~(9'h1ff << data_bits(code));
        end
    endfunction

    // Registers
    reg               tx_on_bit_q;
    reg               tx_ninth_bit_q;
    reg               double_speed_sel_q;
    reg               sync_mode_q;
    reg [2:0]         char_size_sel_q;
    reg [1:0]         parity_mode_sel_q;
    reg               stop_count_sel_q;
    reg [BAUD_W-1:0]  baud_divisor_q;
    reg               tx_done_flag_q;

    reg [8:0]         buf_q;
    reg               buf_full_q;
    reg [8:0]         shift_q;
    reg [2:0]         state_q;
    reg [3:0]         bit_cnt_q;
    reg               par_q;
    reg [4:0]         ovs_q;
    reg               sync_prev_q;

    // AXI handshake state
    reg               aw_held_q;
    reg [7:0]         aw_addr_q;
    reg               w_held_q;
    reg [31:0]        w_data_q;
    reg [3:0]         w_strb_q;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire  = s_axi_wvalid && s_axi_wready;
    wire [7:0]  wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    wire have_aw = aw_held_q || aw_fire;
    wire have_w  = w_held_q || w_fire;
    wire wr_go   = have_aw && have_w && !s_axi_bvalid;
    wire wr_lane0 = wr_go && wr_strb[0];

    wire wr_data_reg = wr_lane0 && (wr_addr == `SFT_OFF_DATA);
    wire wr_status   = wr_lane0 && (wr_addr == `SFT_OFF_STATUS);
    wire wr_ctrl     = wr_lane0 && (wr_addr == `SFT_OFF_CTRL);
    wire wr_format   = wr_lane0 && (wr_addr == `SFT_OFF_FORMAT);
    wire wr_baud     = wr_go && (wr_addr == `SFT_OFF_BAUD);
    wire addr_ok     = (wr_addr == `SFT_OFF_DATA) || (wr_addr == `SFT_OFF_STATUS) ||
                       (wr_addr == `SFT_OFF_CTRL) || (wr_addr == `SFT_OFF_FORMAT) ||
                       (wr_addr == `SFT_OFF_BAUD);

    // Format change detection aborts the frame in flight
    wire [5:0] fmt_new = wr_data[5:0];
    wire fmt_change = wr_format &&
        (fmt_new != {stop_count_sel_q, parity_mode_sel_q, char_size_sel_q});

    // Bit-rate enable
    wire baud_tick;
    sft_baud_gen #(
        .W       (BAUD_W)
    ) u_baud (
        .aclk    (aclk),
        .aresetn (aresetn),
        .reload  (wr_baud),
        .divisor (baud_divisor_q),
        .tick    (baud_tick)
    );

    // Sync pin edge; data changes on rising edge
    wire sync_rise = sync_clock_pin && !sync_prev_q;
    wire [4:0] ovs_len = double_speed_sel_q ? `SFT_OVS_DOUBLE : `SFT_OVS_NORMAL;
    wire async_bit = baud_tick && (ovs_q == 5'h01);
    wire bit_en = sync_mode_q ? sync_rise : async_bit;

    wire frame_end = bit_en && ((state_q == ST_STOP2) ||
                     (state_q == ST_STOP1 && !stop_count_sel_q));
    // Sync mode waits for a bit clock edge so the start bit is whole
    wire load_shift = buf_full_q && tx_on_bit_q &&
                      ((state_q == ST_IDLE && (bit_en || !sync_mode_q)) || frame_end);
    wire parity_on_bit = parity_mode_sel_q[1];

    always @(posedge aclk)
    begin
        if (!aresetn)
            sync_prev_q <= 1'b0;
        else
            sync_prev_q <= sync_clock_pin;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
            ovs_q <= `SFT_OVS_NORMAL;
        else if (state_q == ST_IDLE || wr_baud)
            ovs_q <= ovs_len;
        else if (baud_tick)
            ovs_q <= (ovs_q == 5'h01) ? ovs_len : ovs_q - 5'h01;
    end

    // Configuration registers
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_on_bit_q        <= 1'b0;
            tx_ninth_bit_q     <= 1'b0;
            double_speed_sel_q <= 1'b0;
            sync_mode_q        <= 1'b0;
            char_size_sel_q    <= `SFT_SIZE_8;
            parity_mode_sel_q  <= 2'h0;
            stop_count_sel_q   <= 1'b0;
            baud_divisor_q     <= {BAUD_W{1'b0}};
        end
        else
        begin
            if (wr_ctrl)
            begin
                tx_on_bit_q        <= wr_data[`SFT_CT_TX_ON];
                tx_ninth_bit_q     <= wr_data[`SFT_CT_NINTH];
                double_speed_sel_q <= wr_data[`SFT_CT_DOUBLE];
                sync_mode_q        <= wr_data[`SFT_CT_SYNC];
            end
            if (wr_format)
            begin
                char_size_sel_q   <= wr_data[`SFT_FM_SIZE_HI:`SFT_FM_SIZE_LO];
                parity_mode_sel_q <= wr_data[`SFT_FM_PAR_HI:`SFT_FM_PAR_LO];
                stop_count_sel_q  <= wr_data[`SFT_FM_STOP];
            end
            if (wr_baud)
                baud_divisor_q <= wr_data[BAUD_W-1:0];
        end
    end

    // Transmit buffer and frame engine
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            buf_q          <= 9'h000;
            buf_full_q     <= 1'b0;
            shift_q        <= 9'h000;
            state_q        <= ST_IDLE;
            bit_cnt_q      <= 4'h0;
            par_q          <= 1'b0;
            tx_done_flag_q <= 1'b0;
        end
        else
        begin
            // Data write fills the buffer; a load in the same cycle empties the old one
            if (wr_data_reg)
            begin
                buf_q      <= {tx_ninth_bit_q, wr_data[7:0]};
                buf_full_q <= 1'b1;
            end
            else if (load_shift)
                buf_full_q <= 1'b0;

            // Set beats a simultaneous W1C clear
            if (frame_end && !buf_full_q)
                tx_done_flag_q <= 1'b1;
            else if (wr_status && wr_data[`SFT_ST_DONE])
                tx_done_flag_q <= 1'b0;

            if (fmt_change)
                state_q <= ST_IDLE;
            else if (load_shift)
            begin
                shift_q   <= buf_q & data_mask(char_size_sel_q);
                par_q     <= ^(buf_q & data_mask(char_size_sel_q)) ^ parity_mode_sel_q[0];
                bit_cnt_q <= data_bits(char_size_sel_q);
                state_q   <= ST_START;
            end
            else if (bit_en)
            begin
                case (state_q)
                    ST_START:
                        state_q <= ST_DATA;
                    ST_DATA:
                    begin
                        shift_q   <= {1'b0, shift_q[8:1]};
                        bit_cnt_q <= bit_cnt_q - 4'h1;
                        if (bit_cnt_q == 4'h1)
                            state_q <= parity_on_bit ? ST_PARITY : ST_STOP1;
                    end
                    ST_PARITY:
                        state_q <= ST_STOP1;
                    ST_STOP1:
                        state_q <= stop_count_sel_q ? ST_STOP2 : ST_IDLE;
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Serial pin: transmitter owns it while enabled, and after disable until both buffer and shifter empty
    wire owned_d = tx_on_bit_q || buf_full_q || (state_q != ST_IDLE);
    reg line_d;
    always @*
    begin
        case (state_q)
            ST_START:  line_d = 1'b0;
            ST_DATA:   line_d = shift_q[0];
            ST_PARITY: line_d = par_q;
            default:   line_d = 1'b1;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            serial_out_pin <= 1'b1;
            tx_pin_owned   <= 1'b0;
        end
        else
        begin
            tx_pin_owned   <= owned_d;
            serial_out_pin <= owned_d ? line_d : port_out;
        end
    end

    // AXI write channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q     <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_held_q      <= 1'b0;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SFT_RESP_OKAY;
        end
        else
        begin
            if (aw_fire && !wr_go)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_held_q <= 1'b0;
            if (w_fire && !wr_go)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (wr_go)
                w_held_q <= 1'b0;
            s_axi_awready <= !s_axi_awready && !aw_held_q && !aw_fire && !s_axi_bvalid && !wr_go;
            s_axi_wready  <= !s_axi_wready && !w_held_q && !w_fire && !s_axi_bvalid && !wr_go;
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_ok ? `SFT_RESP_OKAY : `SFT_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // AXI read channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SFT_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `SFT_RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                if (s_axi_araddr == `SFT_OFF_DATA)
                    s_axi_rdata <= 32'h0000_0000;
                else if (s_axi_araddr == `SFT_OFF_STATUS)
                begin
                    s_axi_rdata[`SFT_ST_BUF_FREE] <= !buf_full_q;
                    s_axi_rdata[`SFT_ST_DONE]     <= tx_done_flag_q;
                    s_axi_rdata[`SFT_ST_BUSY]     <= (state_q != ST_IDLE);
                end
                else if (s_axi_araddr == `SFT_OFF_CTRL)
                    s_axi_rdata[3:0] <= {sync_mode_q, double_speed_sel_q, tx_ninth_bit_q, tx_on_bit_q};
                else if (s_axi_araddr == `SFT_OFF_FORMAT)
                    s_axi_rdata[5:0] <= {stop_count_sel_q, parity_mode_sel_q, char_size_sel_q};
                else if (s_axi_araddr == `SFT_OFF_BAUD)
                    s_axi_rdata[BAUD_W-1:0] <= baud_divisor_q;
                else
                    s_axi_rresp <= `SFT_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: verif/sft_assertions.sv
// Port-level checks of the serial frame transmitter
`timescale 1ns/100ps
`default_nettype none
module sft_checks (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Serial pins
    input wire logic        port_out,
    input wire logic        serial_out_pin,
    input wire logic        tx_pin_owned
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_b_after_wr: assert property (wr_taken |=> s_axi_bvalid) else $error("no write response");
    chk_r_after_rd: assert property (rd_taken |=> s_axi_rvalid) else $error("no read data");
    chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
    chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready too long");
    chk_pin_port: assert property (!tx_pin_owned && !$past(tx_pin_owned) && !$past(tx_pin_owned, 2)
        && $stable(port_out) && $past(port_out, 2) == port_out |-> serial_out_pin == port_out)
        else $error("pin not following port");
    chk_release_high: assert property ($fell(tx_pin_owned) |-> $past(serial_out_pin))
        else $error("pin released mid frame");
    chk_reset_idle: assert property ($past(aresetn) == 1'b0 |-> serial_out_pin && !tx_pin_owned)
        else $error("line not idle after reset");
endmodule
`default_nettype wire

// File: verif/sft_rx_model.sv
// Far-end serial receiver model sampling the transmit line
`timescale 1ns/100ps
`default_nettype none
module sft_rx_model (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Line and bit clock
    input  wire logic        rx_line,
    input  wire logic        sync_clock_pin,
    // Settings
    input  wire logic        sync_mode,
    input  wire logic [7:0]  bit_clks,
    input  wire logic [3:0]  nbits,
    // Results
    output logic [7:0]       frames,
    output logic [11:0]      last_frame,
    output logic             frame_err
);
    logic        busy;
    logic        sync_q;
    logic        strobe;
    logic [7:0]  cnt;
    logic [3:0]  idx;
    logic [11:0] shf;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            busy = 1'b0;
            sync_q = 1'b0;
            cnt = 8'h00;
            frames = 8'h00;
            frame_err = 1'b0;
        end
        else
        begin
            strobe = 1'b0;
            if (sync_mode)
                strobe = sync_q && !sync_clock_pin;
            else if (busy || !rx_line)
            begin
                cnt = cnt + 8'h01;
                strobe = cnt == (busy ? bit_clks : {1'b0, bit_clks[7:1]});
                if (strobe)
                    cnt = 8'h00;
            end
            else
                cnt = 8'h00;
            sync_q = sync_clock_pin;
            if (strobe && !busy && !rx_line)
            begin
                busy = 1'b1;
                idx = 4'h0;
                shf = 12'h000;
            end
            else if (strobe && busy)
            begin
                shf[idx] = rx_line;
                idx = idx + 4'h1;
                if (idx == nbits)
                begin
                    // Second stop bit never looked at
                    busy = 1'b0;
                    frames = frames + 8'h01;
                    last_frame = shf;
                    frame_err = !rx_line;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/tb_serial_frame_transmitter.sv
// Self-checking bench of the serial frame transmitter
`timescale 1ns/100ps
`default_nettype none
`include "sft_map.vh"
`define CHK(w, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("FAIL %s exp %h got %h", w, e, g); end end
module tb_serial_frame_transmitter;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  aw_a = 8'h00, ar_a = 8'h00;
    logic [31:0] w_d = 32'h0, r_d;
    logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, pin, owned;
    logic [1:0]  b_resp, r_resp;
    logic        sclk = 1'b0, port_out = 1'b1, sync_run = 1'b0, m_sync = 1'b0;
    logic [7:0]  m_bits = 8'h10, frames;
    logic [3:0]  m_n = 4'ha;
    logic [11:0] last_frame;
    logic        frame_err;
    int          fail_count = 0, samples_checked = 0;
    always #5 aclk = ~aclk;
    always
    begin
        repeat (10) @(posedge aclk);
        if (sync_run)
            sclk <= ~sclk;
    end
    sft_transmitter dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .sync_clock_pin(sclk), .port_out(port_out), .serial_out_pin(pin), .tx_pin_owned(owned));
    sft_rx_model far_u (.aclk(aclk), .aresetn(aresetn), .rx_line(pin), .sync_clock_pin(sclk), .sync_mode(m_sync),
        .bit_clks(m_bits), .nbits(m_n), .frames(frames), .last_frame(last_frame), .frame_err(frame_err));
    task automatic stop_test();
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim)
        begin
            $display("FAIL timeout exp %0d got %0d", lim, n);
            fail_count++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        aw_a <= a;
        aw_v <= 1'b1;
        w_d <= d;
        w_v <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (aw_v && aw_rdy)
                aw_v <= 1'b0;
            if (w_v && w_rdy)
                w_v <= 1'b0;
            if (b_v && b_r)
            begin
                r = b_resp;
                b_r <= 1'b0;
                break;
            end
            // Ready comes a cycle late so the slave must hold its answer
            if (b_v)
                b_r <= 1'b1;
        end
        tmo(n, 100);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        ar_a <= a;
        ar_v <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (ar_v && ar_rdy)
                ar_v <= 1'b0;
            if (r_v && r_r)
            begin
                d = r_d;
                r = r_resp;
                r_r <= 1'b0;
                break;
            end
            if (r_v)
                r_r <= 1'b1;
        end
        tmo(n, 100);
    endtask
    function automatic logic [11:0] exp_frame(input logic [8:0] d, input logic [2:0] sz, input logic [1:0] pm);
        int n;
        logic [11:0] f;
        logic p;
        n = (sz == 3'h7) ? 9 : sz + 5;
        f = 12'h000;
        p = pm[0];
        for (int i = 0; i < n; i++)
        begin
            f[i] = d[i];
            p = p ^ d[i];
        end
        if (pm[1])
        begin
            f[n] = p;
            n++;
        end
        f[n] = 1'b1;
        return f;
    endfunction
    task automatic got(input logic [7:0] target, input logic [11:0] e);
        int n;
        for (n = 0; n < 3000 && frames !== target; n++)
            @(posedge aclk);
        tmo(n, 3000);
        `CHK("frame bits", e, last_frame)
        `CHK("first stop", 1'b0, frame_err)
    endtask
    task automatic wait_done();
        int n;
        logic [31:0] s;
        logic [1:0] r;
        for (n = 0; n < 300; n++)
        begin
            rd(`SFT_OFF_STATUS, s, r);
            if (s[`SFT_ST_DONE] === 1'b1)
                break;
        end
        tmo(n, 300);
        wr(`SFT_OFF_STATUS, `SFT_ST_DONE_W1C, r);
    endtask
    task automatic send(input logic [2:0] sz, input logic [1:0] pm, input logic st, input logic [3:0] ct,
        input logic [8:0] d);
        logic [1:0] r;
        logic [7:0] f0;
        m_n <= 4'((sz == 3'h7) ? 9 : sz + 5) + {3'h0, pm[1]} + 4'h1;
        wr(`SFT_OFF_FORMAT, {26'h0, st, pm, sz}, r);
        wr(`SFT_OFF_CTRL, {28'h0, ct[3:2], d[8], ct[0]}, r);
        f0 = frames;
        wr(`SFT_OFF_DATA, {24'hffffff, d[7:0]}, r);
        got(f0 + 8'h01, exp_frame(d, sz, pm));
        wait_done();
    endtask
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        `CHK("idle pin", 1'b1, pin)
        `CHK("owned", 1'b0, owned)
        rd(`SFT_OFF_STATUS, d, r);
        `CHK("status", 32'h1, d)
        rd(`SFT_OFF_FORMAT, d, r);
        `CHK("format", 32'h3, d)
        rd(8'h20, d, r);
        `CHK("unmapped rd", {`SFT_RESP_SLVERR, 32'h0}, {r, d})
        wr(8'h20, 32'hffffffff, r);
        `CHK("unmapped wr", `SFT_RESP_SLVERR, r)
        wr(`SFT_OFF_BAUD, 32'h0, r);
        `CHK("baud wr", `SFT_RESP_OKAY, r)
    endtask
    task automatic t_formats();
        int i;
        i = 0;
        for (int s = 0; s < 5; s++)
            for (int p = 0; p < 3; p++)
                for (int st = 0; st < 2; st++)
                begin
                    // All thirty formats
                    send((s == 4) ? 3'h7 : 3'(s), (p == 0) ? 2'h0 : 2'(p + 1), st[0], 4'h1,
                        {i[0], 8'h5a ^ 8'(i * 37)});
                    i++;
                end
    endtask
    task automatic t_b2b();
        int n;
        logic [31:0] s;
        logic [1:0] r;
        logic [7:0] f0;
        m_n <= 4'h9;
        wr(`SFT_OFF_FORMAT, 32'h3, r);
        wr(`SFT_OFF_CTRL, 32'h1, r);
        f0 = frames;
        wr(`SFT_OFF_DATA, 32'h81, r);
        for (n = 0; n < 50; n++)
        begin
            rd(`SFT_OFF_STATUS, s, r);
            if (s[`SFT_ST_BUF_FREE] === 1'b1)
                break;
        end
        tmo(n, 50);
        wr(`SFT_OFF_DATA, 32'h7e, r);
        rd(`SFT_OFF_STATUS, s, r);
        `CHK("buffer held", 2'h0, s[1:0])
        got(f0 + 8'h01, exp_frame(9'h081, 3'h3, 2'h0));
        got(f0 + 8'h02, exp_frame(9'h07e, 3'h3, 2'h0));
        wait_done();
        rd(`SFT_OFF_STATUS, s, r);
        `CHK("done cleared", 1'b0, s[`SFT_ST_DONE])
    endtask
    task automatic t_disable();
        int n;
        logic [1:0] r;
        logic [7:0] f0;
        @(posedge aclk);
        port_out <= 1'b0;
        f0 = frames;
        wr(`SFT_OFF_DATA, 32'h55, r);
        wr(`SFT_OFF_CTRL, 32'h0, r);
        `CHK("still owned", 1'b1, owned)
        got(f0 + 8'h01, exp_frame(9'h055, 3'h3, 2'h0));
        for (n = 0; n < 400 && owned !== 1'b0; n++)
            @(posedge aclk);
        tmo(n, 400);
        repeat (3) @(posedge aclk);
        `CHK("port on pin", 1'b0, pin)
        port_out <= 1'b1;
        wr(`SFT_OFF_CTRL, 32'h1, r);
    endtask
    task automatic t_abort();
        logic [1:0] r;
        wr(`SFT_OFF_DATA, 32'h00, r);
        repeat (40) @(posedge aclk);
        wr(`SFT_OFF_FORMAT, 32'h13, r);
        repeat (3) @(posedge aclk);
        `CHK("aborted line", 1'b1, pin)
        repeat (30) @(posedge aclk);
        `CHK("line stays idle", 1'b1, pin)
        repeat (250) @(posedge aclk);
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_formats();
        m_bits <= 8'h08;
        send(3'h3, 2'h2, 1'b0, 4'h5, 9'h0c3);
        m_bits <= 8'h10;
        m_sync <= 1'b1;
        sync_run <= 1'b1;
        send(3'h3, 2'h3, 1'b1, 4'h9, 9'h03c);
        sync_run <= 1'b0;
        m_sync <= 1'b0;
        t_b2b();
        t_disable();
        t_abort();
        stop_test();
    end
endmodule
bind sft_transmitter sft_checks chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_out(port_out),
    .serial_out_pin(serial_out_pin), .tx_pin_owned(tx_pin_owned));
`default_nettype wire
